// *** shared/tcdma_regs.svh ***
// register map, field positions, reset values and bus timing counts
// assumes byte addresses on a 32-bit apb with an 8-bit offset space
// Summary of operation
// - two channels; channel zero wins ties
// - any-to-fixed, fixed-to-any, fixed-to-fixed, 1M bytes
// - engine never touches 002016 to 003F16
// - byte or word units, 64K units per run
// - pin falling edge or both edges request
// - timer, serial, converter irqs, software trigger request
// - both sides incrementing is refused
// - single mode underflow clears enable
// - repeat mode underflow reloads counter, stays active
// - underflow raises transfer-complete interrupt request
// - active channel moves one unit per request
// - first transfer loads pointer and counter
// - fixed pointer writable only while disabled
// - reads always; enabled reads show working pointer on the incrementing side
// - transfers ignore and leave interrupt state
// - unit is source reads then destination writes
// - odd word on wide bus takes two cycles
// - narrow bus splits words into two bytes
// - bus width pin governs internal accesses too
// - sfr or wait region adds one cycle
// - request flag sets always, clears at start
// - cpu gets one access after channel zero
`ifndef TCDMA_REGS_SVH
`define TCDMA_REGS_SVH
`define TCDMA_OFF_SRC   5'h00
`define TCDMA_OFF_DST   5'h04
`define TCDMA_OFF_RLD   5'h08
`define TCDMA_OFF_CNT   5'h0C
`define TCDMA_OFF_CTL   5'h10
`define TCDMA_CH_SPAN   8'h40
`define TCDMA_OFF_SWREQ 8'h40
`define TCDMA_B_EN      0
`define TCDMA_B_WORD    1
`define TCDMA_B_RPT     2
`define TCDMA_B_SINC    3
`define TCDMA_B_DINC    4
`define TCDMA_B_BOTH    5
`define TCDMA_B_FLAG    6
`define TCDMA_B_SEL_LO  8
`define TCDMA_B_SEL_HI  12
`define TCDMA_PTR_RST   20'h00000
`define TCDMA_CNT_RST   16'h0000
`define TCDMA_SEL_RST   5'h00
`define TCDMA_BLK_LO    20'h00020
`define TCDMA_BLK_HI    20'h0003F
`define TCDMA_SFR_HI    20'h003FF
`define TCDMA_ACC_CYC   2'h1
`define TCDMA_WAIT_CYC  2'h1
`endif

// *** shared/tcdma_pkg.sv ***
// types shared by the transfer engine files
// assumes tcdma_regs.svh supplies all numeric constants
package tcdma_pkg;
	// one-hot channel sequencer states
	typedef enum logic [4:0] {
		st_idle = 5'b00001,
		st_arb  = 5'b00010,
		st_rd   = 5'b00100,
		st_wr   = 5'b01000,
		st_gap  = 5'b10000
	} tcdma_state_e;
	// request source code: 0 software, 1 pin, 2.. peripherals
	typedef logic [4:0] tcdma_sel_t;
endpackage : tcdma_pkg

// *** core/tcdma_bus_cycle.sv ***
// one source read or destination write, an odd or narrow-bus word split into byte cycles
// assumes the system bus answers within the fixed access time
`include "tcdma_regs.svh"
`timescale 1ns/1ps
module tcdma_bus_cycle
	import tcdma_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        start,
	input  wire logic        wr,
	input  wire logic        word,
	input  wire logic        narrow,
	input  wire logic        sw_wait,
	input  wire logic [19:0] addr,
	input  wire logic [15:0] wdata,
	input  wire logic [15:0] mem_rdata,
	output logic             done,
	output logic      [15:0] rdata,
	output logic      [19:0] mem_addr,
	output logic             mem_rd,
	output logic             mem_wr,
	output logic             mem_byte,
	output logic      [15:0] mem_wdata
);
	logic        active;  // access in progress
	logic        part;    // second byte of a split word
	logic        split;   // word done as two byte cycles
	logic        wr_r;    // latched direction
	logic        word_r;  // latched unit size
	logic [19:0] base;    // latched start address
	logic [15:0] wd;      // latched write data
	logic [1:0]  wcnt;    // cycles spent on the current byte or word
	// address and timing of the current byte or word
	wire [19:0] cur     = base + {19'h0, part};
	wire        slow    = (cur <= `TCDMA_SFR_HI) | sw_wait;
	wire [1:0]  len     = slow ? `TCDMA_ACC_CYC + `TCDMA_WAIT_CYC : `TCDMA_ACC_CYC;
	wire        last    = active & (wcnt == len - 2'h1);
	wire        blocked = (cur >= `TCDMA_BLK_LO) & (cur <= `TCDMA_BLK_HI);
	// strobes are masked on the engine's own register range
	assign mem_addr  = cur;
	assign mem_rd    = active & ~wr_r & ~blocked;
	assign mem_wr    = active & wr_r & ~blocked;
	assign mem_byte  = active & (split | ~word_r);
	assign mem_wdata = ~split ? wd : (part ? {8'h00, wd[15:8]} : {8'h00, wd[7:0]});
	wire [15:0] rd_in = blocked ? 16'h0000 : mem_rdata;
	// latch request, step wait count and byte phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			active <= 1'b0;
			part   <= 1'b0;
			split  <= 1'b0;
			wr_r   <= 1'b0;
			word_r <= 1'b0;
			base   <= `TCDMA_PTR_RST;
			wd     <= 16'h0000;
			wcnt   <= 2'h0;
			done   <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (start)
			begin
				// odd word on wide bus or any word on narrow bus
				split  <= word & (narrow | addr[0]);
				active <= 1'b1;
				part   <= 1'b0;
				wr_r   <= wr;
				word_r <= word;
				base   <= addr;
				wd     <= wdata;
				wcnt   <= 2'h0;
			end
			else if (last)
			begin
				wcnt <= 2'h0;
				if (split & ~part)
					part <= 1'b1;
				else
				begin
					active <= 1'b0;
					done   <= 1'b1;
				end
			end
			else if (active)
				wcnt <= wcnt + 2'h1;
		end
	end
	// gather read data from one or two cycles
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rdata <= 16'h0000;
		else if (last & ~wr_r)
		begin
			if (split & ~part)
				rdata[7:0] <= rd_in[7:0];
			else if (split)
				rdata[15:8] <= rd_in[7:0];
			else if (word_r)
				rdata <= rd_in;
			else
				rdata <= {8'h00, rd_in[7:0]};
		end
	end
	chk_no_blocked_acc: assert property (@(posedge pclk) disable iff (!presetn)
		(mem_rd | mem_wr) |-> (mem_addr < `TCDMA_BLK_LO) | (mem_addr > `TCDMA_BLK_HI))
		else $error("access to engine register range");
	chk_split_two_cyc: assert property (@(posedge pclk) disable iff (!presetn)
		start & word & narrow & ~sw_wait & (addr > `TCDMA_SFR_HI) |=> ##1 !done ##1 done)
		else $error("narrow word not two cycles");
endmodule : tcdma_bus_cycle

// *** core/tcdma_top.sv ***
// two-channel cycle-stealing transfer engine with apb registers
// assumes inputs synchronous to pclk and a cpu arbiter on mem_grant
//
// Register access over APB and the address map were chosen for this implementation.
`include "tcdma_regs.svh"
`timescale 1ns/1ps
module tcdma_top
	import tcdma_pkg::*;
#(
	parameter int NUM_PERIPH = 20
) (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  external_request_pin_zero,
	input  wire logic                  external_request_pin_one,
	input  wire logic [NUM_PERIPH-1:0] periph_irq,
	input  wire logic                  byte_pin,
	input  wire logic                  sw_wait,
	output logic                       mem_req,
	input  wire logic                  mem_grant,
	output logic      [19:0]           mem_addr,
	output logic                       mem_rd,
	output logic                       mem_wr,
	output logic                       mem_byte,
	output logic      [15:0]           mem_wdata,
	input  wire logic [15:0]           mem_rdata,
	output logic      [1:0]            done_irq,
	output logic      [1:0]            chan_active
);
	// per-channel programmed state
	logic [19:0]    src [2];   // source pointer
	logic [19:0]    dst [2];   // destination pointer
	logic [19:0]    wptr [2];  // working incrementing pointer
	logic [15:0]    rld [2];   // counter reload value
	logic [15:0]    cnt [2];   // transfer counter
	tcdma_sel_t     rsel [2];  // request source select
	logic [1:0]     en;        // channel enable
	logic [1:0]     word;      // 16-bit units
	logic [1:0]     rpt;       // repeat mode
	logic [1:0]     sinc;      // source increments
	logic [1:0]     dinc;      // destination increments
	logic [1:0]     both;      // both pin edges
	logic [1:0]     flag;      // request pending
	logic [1:0]     first;     // next start reloads
	logic [1:0]     ext_prev;  // pin levels last cycle
	logic [NUM_PERIPH-1:0] per_prev; // irq levels last cycle
	tcdma_state_e   st;        // sequencer state
	tcdma_state_e   next_st;   // sequencer next state
	logic           cur;       // channel being served
	logic           bc_done;   // bus access finished
	logic [15:0]    bc_rdata;  // data read from source

	// request source for one channel
	function automatic logic req_event(
		input tcdma_sel_t s,
		input logic sw,
		input logic fall,
		input logic rise,
		input logic bth,
		input logic [NUM_PERIPH-1:0] pe
	);
		logic [4:0] idx;
		idx = s - 5'h02;
		if (s == 5'h00)
			return sw;
		else if (s == 5'h01)
			return fall | (bth & rise);
		else if (int'(idx) < NUM_PERIPH)
			return pe[idx];
		else
			return 1'b0;
	endfunction : req_event

	// control word as software reads it
	function automatic logic [31:0] ctl_word(input logic c);
		ctl_word = {19'h0, rsel[c], 1'b0, flag[c], both[c], dinc[c],
			sinc[c], rpt[c], word[c], en[c]};
	endfunction : ctl_word

	// edges of pins and peripheral irq lines
	wire [1:0] ext_now = {external_request_pin_one, external_request_pin_zero};
	wire [1:0] ext_fall = ext_prev & ~ext_now;
	wire [1:0] ext_rise = ~ext_prev & ext_now;
	wire [NUM_PERIPH-1:0] per_edge = periph_irq & ~per_prev;

	// apb decode
	wire       acc_wr  = psel & penable & pwrite;
	wire       in_ch   = paddr < `TCDMA_CH_SPAN;
	wire       ach     = paddr[5];
	wire [4:0] aoff    = paddr[4:0];
	wire [1:0] chsel   = in_ch ? (ach ? 2'b10 : 2'b01) : 2'b00;
	wire       off_ok  = (aoff == `TCDMA_OFF_SRC) | (aoff == `TCDMA_OFF_DST) |
		(aoff == `TCDMA_OFF_RLD) | (aoff == `TCDMA_OFF_CNT) | (aoff == `TCDMA_OFF_CTL);
	wire       hit     = in_ch ? off_ok : (paddr == `TCDMA_OFF_SWREQ);
	wire [1:0] wr_src  = {2{acc_wr & (aoff == `TCDMA_OFF_SRC)}} & chsel;
	wire [1:0] wr_dst  = {2{acc_wr & (aoff == `TCDMA_OFF_DST)}} & chsel;
	wire [1:0] wr_rld  = {2{acc_wr & (aoff == `TCDMA_OFF_RLD)}} & chsel;
	wire [1:0] wr_ctl  = {2{acc_wr & (aoff == `TCDMA_OFF_CTL)}} & chsel;
	wire [1:0] sw_trig = (acc_wr & (paddr == `TCDMA_OFF_SWREQ)) ? pwdata[1:0] : 2'b00;
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~hit;

	// enabled channels show the working pointer on the incrementing side
	wire [19:0] rd_src = (en[ach] & sinc[ach]) ? wptr[ach] : src[ach];
	wire [19:0] rd_dst = (en[ach] & dinc[ach]) ? wptr[ach] : dst[ach];
	wire [31:0] rd_val =
		~hit ? 32'h0000_0000 :
		~in_ch ? 32'h0000_0000 :
		(aoff == `TCDMA_OFF_SRC) ? {12'h000, rd_src} :
		(aoff == `TCDMA_OFF_DST) ? {12'h000, rd_dst} :
		(aoff == `TCDMA_OFF_RLD) ? {16'h0000, rld[ach]} :
		(aoff == `TCDMA_OFF_CNT) ? {16'h0000, cnt[ach]} :
		ctl_word(ach);

	// request events; no cpu interrupt state is read or changed
	wire [1:0] ev;
	assign ev[0] = req_event(rsel[0], sw_trig[0], ext_fall[0], ext_rise[0], both[0], per_edge);
	assign ev[1] = req_event(rsel[1], sw_trig[1], ext_fall[1], ext_rise[1], both[1], per_edge);

	// sequencer events
	wire [1:0] pend     = en & flag;
	wire       grant_go = (st == st_arb) & mem_grant;
	wire       rd_done  = (st == st_rd) & bc_done;
	wire       wr_done  = (st == st_wr) & bc_done;
	wire [1:0] start_c  = grant_go ? (cur ? 2'b10 : 2'b01) : 2'b00;
	wire [1:0] done_c   = wr_done ? (cur ? 2'b10 : 2'b01) : 2'b00;
	wire       uflow    = cnt[cur] == 16'h0000;

	// effective addresses: registers until the first reload
	wire [19:0] src_a = (sinc[cur] & ~first[cur]) ? wptr[cur] : src[cur];
	wire [19:0] dst_a = (dinc[cur] & ~first[cur]) ? wptr[cur] : dst[cur];
	wire [19:0] bc_addr  = (st == st_arb) ? src_a : dst_a;
	wire        bc_start = grant_go | rd_done;
	assign mem_req     = (st == st_arb) | (st == st_rd) | (st == st_wr);
	assign chan_active = en;

	// sequencer next state
	always_comb
	begin
		next_st = st;
		case (st)
			st_idle: if (|pend) next_st = st_arb;
			st_arb:  if (mem_grant) next_st = st_rd;
			st_rd:   if (bc_done) next_st = st_wr;
			st_wr:   if (bc_done) next_st = cur ? st_idle : st_gap;
			st_gap:  next_st = st_idle;
			default: next_st = st_idle;
		endcase
	end

	// sequencer state and served channel
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st  <= st_idle;
			cur <= 1'b0;
		end
		else
		begin
			st <= next_st;
			if (st == st_idle && |pend)
				cur <= ~pend[0];
		end
	end

	// edge history and apb read data captured in setup
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ext_prev <= 2'b11;
			per_prev <= '0;
			prdata   <= 32'h0000_0000;
		end
		else
		begin
			ext_prev <= ext_now;
			per_prev <= periph_irq;
			if (psel & ~penable & ~pwrite)
				prdata <= rd_val;
		end
	end

	// per-channel registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int c = 0; c < 2; c++)
			begin
				src[c]  <= `TCDMA_PTR_RST;
				dst[c]  <= `TCDMA_PTR_RST;
				wptr[c] <= `TCDMA_PTR_RST;
				rld[c]  <= `TCDMA_CNT_RST;
				cnt[c]  <= `TCDMA_CNT_RST;
				rsel[c] <= `TCDMA_SEL_RST;
			end
			{en, word, rpt, sinc, dinc, both, flag, first} <= 16'h0000;
			done_irq <= 2'b00;
		end
		else
		begin
			done_irq <= 2'b00;
			for (int c = 0; c < 2; c++)
			begin
				// set beats both clears
				flag[c] <= ev[c] | (flag[c] & ~start_c[c] &
					~(wr_ctl[c] & ~pwdata[`TCDMA_B_FLAG]));
				if (start_c[c] & first[c])
				begin
					wptr[c]  <= sinc[c] ? src[c] : dst[c];
					cnt[c]   <= rld[c];
					first[c] <= 1'b0;
				end
				if (done_c[c])
				begin
					if (sinc[c] | dinc[c])
						wptr[c] <= wptr[c] + (word[c] ? 20'h00002 : 20'h00001);
					cnt[c] <= uflow & rpt[c] ? rld[c] : cnt[c] - 16'h0001;
					if (uflow & ~rpt[c])
						en[c] <= 1'b0;
					done_irq[c] <= uflow;
				end
				if (wr_src[c] & (sinc[c] | ~en[c]))
					src[c] <= pwdata[19:0];
				if (wr_dst[c] & (dinc[c] | ~en[c]))
					dst[c] <= pwdata[19:0];
				if (wr_rld[c])
					rld[c] <= pwdata[15:0];
				if (wr_ctl[c])
				begin
					en[c]    <= pwdata[`TCDMA_B_EN];
					first[c] <= pwdata[`TCDMA_B_EN];
					word[c]  <= pwdata[`TCDMA_B_WORD];
					rpt[c]   <= pwdata[`TCDMA_B_RPT];
					sinc[c]  <= pwdata[`TCDMA_B_SINC];
					dinc[c]  <= pwdata[`TCDMA_B_DINC] & ~pwdata[`TCDMA_B_SINC];
					both[c]  <= pwdata[`TCDMA_B_BOTH];
					rsel[c]  <= pwdata[`TCDMA_B_SEL_HI:`TCDMA_B_SEL_LO];
				end
			end
		end
	end

	// bus access engine; width follows the pin for all areas
	tcdma_bus_cycle u_bus (
		.pclk      (pclk),
		.presetn   (presetn),
		.start     (bc_start),
		.wr        (rd_done),
		.word      (word[cur]),
		.narrow    (byte_pin),
		.sw_wait   (sw_wait),
		.addr      (bc_addr),
		.wdata     (bc_rdata),
		.mem_rdata (mem_rdata),
		.done      (bc_done),
		.rdata     (bc_rdata),
		.mem_addr  (mem_addr),
		.mem_rd    (mem_rd),
		.mem_wr    (mem_wr),
		.mem_byte  (mem_byte),
		.mem_wdata (mem_wdata)
	);

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_prio_chan_zero: assert property (
		st == st_idle && pend == 2'b11 |=> cur == 1'b0)
		else $error("channel one won a tie");
	chk_single_stop: assert property (
		wr_done && !cur && cnt[0] == 16'h0000 && !rpt[0] && !wr_ctl[0] |=> !en[0])
		else $error("single mode did not stop");
	chk_repeat_reload: assert property (
		wr_done && !cur && cnt[0] == 16'h0000 && rpt[0] && !wr_ctl[0]
		|=> en[0] && cnt[0] == $past(rld[0]))
		else $error("repeat mode did not reload");
	chk_irq_underflow: assert property (
		done_irq[0] |-> $past(wr_done && !cur && cnt[0] == 16'h0000))
		else $error("interrupt without underflow");
	chk_first_load: assert property (
		grant_go && !cur && first[0] && !wr_ctl[0] |=> cnt[0] == $past(rld[0]))
		else $error("counter not reloaded on first start");
	chk_fixed_guard: assert property (
		en[0] && !sinc[0] && wr_src[0] |=> src[0] == $past(src[0]))
		else $error("fixed pointer written while enabled");
	chk_flag_clear: assert property (
		grant_go && !cur && !ev[0] |=> !flag[0])
		else $error("request flag not cleared at start");
	chk_flag_set: assert property (
		ev[1] |=> flag[1])
		else $error("request lost");
	chk_gap_after_zero: assert property (
		wr_done && !cur |=> !mem_req ##1 (st == st_idle))
		else $error("no cpu slot after channel zero");
	chk_count_dec: assert property (
		wr_done && !cur && cnt[0] != 16'h0000 && !wr_ctl[0]
		|=> cnt[0] == $past(cnt[0]) - 16'h0001)
		else $error("counter did not step down");
	chk_unit_bounded: assert property (
		grant_go |=> ##[2:10] wr_done)
		else $error("unit transfer did not finish");
endmodule : tcdma_top

// *** bench/tcdma_mem_model.sv ***
// memory and cpu-side arbiter on the engine's system bus
// assumes one access per strobe cycle; cpu yields after grant_lag cycles
`timescale 1ns/1ps
module tcdma_mem_model (
	input  wire logic        pclk,
	input  wire logic [1:0]  grant_lag,
	input  wire logic        mem_req,
	input  wire logic [19:0] mem_addr,
	input  wire logic        mem_rd,
	input  wire logic        mem_wr,
	input  wire logic        mem_byte,
	input  wire logic [15:0] mem_wdata,
	output logic             mem_grant,
	output logic      [15:0] mem_rdata
);
	logic [7:0]  mem [0:4095];   // byte store, low twelve address bits
	logic [1:0]  lag_cnt = 2'h0; // cycles the cpu kept the bus
	logic [15:0] last_rd = 16'h0; // last word put on the bus
	wire  [11:0] a0      = mem_addr[11:0];
	wire  [11:0] a1      = a0 + 12'h1;
	// fill with an address pattern
	initial
	begin
		for (int i = 0; i < 4096; i++)
			mem[i] = 8'(i) ^ 8'hA5;
	end
	// cpu finishes its own access before handing over
	assign mem_grant = mem_req && (lag_cnt >= grant_lag);
	always @(posedge pclk)
	begin
		lag_cnt <= (mem_req && !mem_grant) ? lag_cnt + 2'h1 : 2'h0;
	end
	// released bus shows the inverse of the last value
	always_comb
	begin
		if (!mem_rd)
			mem_rdata = ~last_rd;
		else if (mem_byte)
			mem_rdata = {~mem[a0], mem[a0]};
		else
			mem_rdata = {mem[a1], mem[a0]};
	end
	// store writes, bytes ride on the low lane
	always @(posedge pclk)
	begin
		if (mem_rd) last_rd <= mem_rdata;
		if (mem_wr) mem[a0] <= mem_wdata[7:0];
		if (mem_wr && !mem_byte) mem[a1] <= mem_wdata[15:8];
	end
endmodule : tcdma_mem_model

// *** bench/test_two_channel_cycle_steal_dma.sv ***
// self-checking bench: table of transfer runs, then reset and corner cases
// assumes the memory model fills byte a with a[7:0]^A5
`timescale 1ns/1ps
`include "tcdma_regs.svh"
module test_two_channel_cycle_steal_dma;
	typedef struct packed {
		logic        ch;  // channel
		logic [7:0]  ctl; // control byte
		logic [19:0] src;
		logic [19:0] dst;
		logic [3:0]  rld; // reload, units minus one
		logic        bp;  // narrow bus
		logic        sw;  // software wait
		logic [3:0]  rdc; // read cycles per unit
		logic        sp;  // word split in bytes
	} tcdma_row_s;
	tcdma_row_s  rows [6] = '{
		'{1'b0, 8'h09, 20'h01100, 20'h01800, 4'h2, 1'b0, 1'b0, 4'h1, 1'b0},
		'{1'b1, 8'h13, 20'h01200, 20'h01900, 4'h1, 1'b0, 1'b0, 4'h1, 1'b0},
		'{1'b0, 8'h07, 20'h01301, 20'h01A01, 4'h1, 1'b0, 1'b0, 4'h2, 1'b1},
		'{1'b1, 8'h0B, 20'h01400, 20'h01B00, 4'h0, 1'b1, 1'b0, 4'h2, 1'b1},
		'{1'b0, 8'h11, 20'h01500, 20'h01C00, 4'h1, 1'b0, 1'b1, 4'h2, 1'b0},
		'{1'b1, 8'h01, 20'h00100, 20'h01D00, 4'h0, 1'b0, 1'b0, 4'h2, 1'b0}};
	logic        pclk       = 1'b0;
	logic        presetn    = 1'b0;
	logic        psel       = 1'b0;
	logic        penable    = 1'b0;
	logic        pwrite     = 1'b0;
	logic [7:0]  paddr      = 8'h00;
	logic [31:0] pwdata     = 32'h0;
	logic [1:0]  pins       = 2'h3;  // request pins idle high
	logic [19:0] periph_irq = 20'h0;
	logic        byte_pin   = 1'b0;
	logic        sw_wait    = 1'b0;
	logic [1:0]  grant_lag  = 2'h0;  // cpu hold before grant
	logic [31:0] prdata, rd_q;
	logic        pready, pslverr, err_q, mem_req, mem_grant, mem_rd, mem_wr, mem_byte;
	logic [19:0] mem_addr;
	logic [15:0] mem_wdata, mem_rdata;
	logic [1:0]  done_irq, chan_active;
	int          n_errors = 0;
	int          checks_done = 0;
	int          units = 0, rd_cyc = 0, blk_hit = 0, low_run = 0, last_low = 0;
	int          irq_n [2] = '{0, 0};
	logic        req_d   = 1'b0;
	logic [19:0] last_wa = 20'h0;
	logic [15:0] last_wd = 16'h0;
	always #12.5 pclk = ~pclk;
	tcdma_top #(.NUM_PERIPH(20)) u_tcdma_top (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .external_request_pin_zero(pins[0]),
		.external_request_pin_one(pins[1]), .periph_irq(periph_irq), .byte_pin(byte_pin),
		.sw_wait(sw_wait), .mem_req(mem_req), .mem_grant(mem_grant), .mem_addr(mem_addr),
		.mem_rd(mem_rd), .mem_wr(mem_wr), .mem_byte(mem_byte), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .done_irq(done_irq), .chan_active(chan_active));
	tcdma_mem_model u_tcdma_mem_model (.pclk(pclk), .grant_lag(grant_lag), .mem_req(mem_req),
		.mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_byte(mem_byte),
		.mem_wdata(mem_wdata), .mem_grant(mem_grant), .mem_rdata(mem_rdata));
	// bus monitor: units, read cycles, idle runs, last write
	always @(posedge pclk)
	begin
		req_d <= mem_req;
		low_run <= mem_req ? 0 : low_run + 1;
		if (mem_req && !req_d) last_low <= low_run;
		if (!mem_req && req_d) units <= units + 1;
		if (mem_rd) rd_cyc <= rd_cyc + 1;
		if ((mem_rd || mem_wr) && mem_addr >= 20'h20 && mem_addr <= 20'h3F) blk_hit <= blk_hit + 1;
		if (mem_wr) last_wa <= mem_addr;
		if (mem_wr) last_wd <= mem_wdata;
		irq_n[0] <= irq_n[0] + int'(done_irq[0]);
		irq_n[1] <= irq_n[1] + int'(done_irq[1]);
	end
	function automatic logic [7:0] pat(input logic [19:0] a);
		return a[7:0] ^ 8'hA5;
	endfunction : pat
	function automatic logic [7:0] ra(input logic c, input logic [4:0] o);
		return {2'b00, c, o};
	endfunction : ra
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		n = 0;
		while (pready !== 1'b1)
		begin
			n++;
			if (n > 50)
			begin
				n_errors++;
				report_and_stop();
			end
			@(posedge pclk);
		end
		rd_q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	// wait until the unit count reaches t
	task automatic wait_units(input int t);
		int n;
		n = 0;
		while (units < t)
		begin
			n++;
			if (n > 300)
			begin
				n_errors++;
				report_and_stop();
			end
			@(posedge pclk);
		end
		repeat (3) @(posedge pclk);
	endtask : wait_units
	initial
	begin
		tcdma_row_s  r;
		logic [19:0] sz, s, d;
		logic [15:0] ed, wd;
		int          u0, c0, i0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// table of software-triggered runs
		for (int i = 0; i < 6; i++)
		begin
			r = rows[i];
			byte_pin <= r.bp;
			sw_wait <= r.sw;
			sz = r.ctl[1] ? 20'h2 : 20'h1;
			apb(1'b1, ra(r.ch, `TCDMA_OFF_SRC), {12'h0, r.src});
			apb(1'b1, ra(r.ch, `TCDMA_OFF_DST), {12'h0, r.dst});
			apb(1'b1, ra(r.ch, `TCDMA_OFF_RLD), {28'h0, r.rld});
			apb(1'b1, ra(r.ch, `TCDMA_OFF_CTL), {24'h0, r.ctl});
			u0 = units;
			c0 = rd_cyc;
			i0 = irq_n[r.ch];
			for (int k = 0; k <= int'(r.rld); k++)
			begin
				apb(1'b1, `TCDMA_OFF_SWREQ, 32'h1 << r.ch);
				wait_units(u0 + k + 1);
			end
			s = r.src + (r.ctl[3] ? {16'h0, r.rld} * sz : 20'h0);
			d = r.dst + (r.ctl[4] ? {16'h0, r.rld} * sz : 20'h0);
			ed = !r.ctl[1] ? {8'h00, pat(s)} : (r.sp ? {8'h00, pat(s + 20'h1)} : {pat(s + 20'h1), pat(s)});
			wd = (r.ctl[1] && !r.sp) ? last_wd : {8'h00, last_wd[7:0]};
			check(rd_cyc - c0, (int'(r.rld) + 1) * int'(r.rdc));
			check(irq_n[r.ch] - i0, 1);
			check({31'h0, chan_active[r.ch]}, {31'h0, r.ctl[2]});
			check({12'h0, last_wa}, {12'h0, d + {19'h0, r.sp}});
			check({16'h0, wd}, {16'h0, ed});
			if (r.ctl[2])
				apb(1'b1, ra(r.ch, `TCDMA_OFF_CTL), 32'h0);
			check({31'h0, chan_active[r.ch]}, 32'h0);
		end
		// reset in mid-run
		apb(1'b1, ra(1'b0, `TCDMA_OFF_CTL), 32'h9);
		apb(1'b1, `TCDMA_OFF_SWREQ, 32'h1);
		presetn <= 1'b0;
		repeat (10) @(posedge pclk);
		check({31'h0, mem_req}, 32'h0);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, ra(1'b0, `TCDMA_OFF_CTL), 32'h0);
		check(rd_q, 32'h0);
		apb(1'b0, ra(1'b1, `TCDMA_OFF_SRC), 32'h0);
		check(rd_q, 32'h0);
		check({30'h0, chan_active}, 32'h0);
		apb(1'b0, 8'h7C, 32'h0);
		check({31'h0, err_q}, 32'h1);
		// request flag while disabled, both sides incrementing refused
		u0 = units;
		apb(1'b1, ra(1'b0, `TCDMA_OFF_CTL), 32'h18);
		apb(1'b1, `TCDMA_OFF_SWREQ, 32'h1);
		apb(1'b0, ra(1'b0, `TCDMA_OFF_CTL), 32'h0);
		check(rd_q, 32'h48);
		apb(1'b1, ra(1'b0, `TCDMA_OFF_CTL), 32'h08);
		apb(1'b0, ra(1'b0, `TCDMA_OFF_CTL), 32'h0);
		check(rd_q, 32'h08);
		check(units - u0, 0);
		// fixed pointer locked, working pointer, re-arm on enable
		apb(1'b1, ra(1'b0, `TCDMA_OFF_SRC), 32'h1100);
		apb(1'b1, ra(1'b0, `TCDMA_OFF_DST), 32'h1800);
		apb(1'b1, ra(1'b0, `TCDMA_OFF_RLD), 32'h3);
		for (int j = 1; j < 3; j++)
		begin
			apb(1'b1, ra(1'b0, `TCDMA_OFF_CTL), 32'h09);
			apb(1'b1, ra(1'b0, `TCDMA_OFF_DST), 32'h1234);
			apb(1'b0, ra(1'b0, `TCDMA_OFF_DST), 32'h0);
			check(rd_q, 32'h1800);
			apb(1'b1, `TCDMA_OFF_SWREQ, 32'h1);
			wait_units(u0 + j);
			apb(1'b0, ra(1'b0, `TCDMA_OFF_SRC), 32'h0);
			check(rd_q, 32'h1101);
			apb(1'b0, ra(1'b0, `TCDMA_OFF_CNT), 32'h0);
			check(rd_q, 32'h2);
		end
		// simultaneous requests with a slow cpu hand-over
		grant_lag <= 2'h2;
		apb(1'b1, ra(1'b0, `TCDMA_OFF_RLD), 32'h0);
		for (int c = 0; c < 2; c++)
		begin
			apb(1'b1, ra(c[0], `TCDMA_OFF_CTL), 32'h0);
			apb(1'b1, ra(c[0], `TCDMA_OFF_DST), 32'h1E00 + 32'(c) * 32'h100);
			apb(1'b1, ra(c[0], `TCDMA_OFF_CTL), 32'h01);
		end
		u0 = units;
		apb(1'b1, `TCDMA_OFF_SWREQ, 32'h3);
		wait_units(u0 + 2);
		check({12'h0, last_wa}, 32'h1F00);
		check(32'(last_low >= 2), 32'h1);
		grant_lag <= 2'h0;
		// source inside the engine's own register range
		apb(1'b1, ra(1'b1, `TCDMA_OFF_SRC), 32'h30);
		apb(1'b1, ra(1'b1, `TCDMA_OFF_DST), 32'h1E80);
		apb(1'b1, ra(1'b1, `TCDMA_OFF_CTL), 32'h01);
		u0 = units;
		c0 = blk_hit;
		apb(1'b1, `TCDMA_OFF_SWREQ, 32'h2);
		wait_units(u0 + 1);
		check(blk_hit - c0, 0);
		check({24'h0, last_wd[7:0]}, 32'h0);
		// pin edges: falling, then both
		for (int c = 0; c < 2; c++)
		begin
			apb(1'b1, ra(c[0], `TCDMA_OFF_CTL), 32'h105);
			u0 = units;
			pins[c] <= 1'b0;
			wait_units(u0 + 1);
			pins[c] <= 1'b1;
			repeat (8) @(posedge pclk);
			check(units - u0, 1);
			apb(1'b1, ra(c[0], `TCDMA_OFF_CTL), 32'h125);
			pins[c] <= 1'b0;
			wait_units(u0 + 2);
			pins[c] <= 1'b1;
			wait_units(u0 + 3);
			apb(1'b1, ra(c[0], `TCDMA_OFF_CTL), 32'h0);
			check(units - u0, 3);
		end
		// every peripheral source, a neighbour firing too
		for (int k = 0; k < 20; k++)
		begin
			apb(1'b1, ra(1'b1, `TCDMA_OFF_CTL), {19'h0, 5'(k + 2), 8'h05});
			u0 = units;
			periph_irq <= (20'h1 << k) | (20'h1 << ((k + 1) % 20));
			wait_units(u0 + 1);
			periph_irq <= 20'h0;
			repeat (4) @(posedge pclk);
			check(units - u0, 1);
		end
		report_and_stop();
	end
endmodule : test_two_channel_cycle_steal_dma
